// File: core/boot_option_byte_decoder.sv
// Boot option byte loader, decoder and option write gate with APB access
//
// Contract
// [RULE1] Option bit 0 clear selects single low-threshold power-on clear, the default.
// [RULE2] Option bit 0 set selects dual-threshold power-on clear.
// [RULE3] Threshold-select writes accepted only from the external programmer, never self-programming.
// [RULE4] Boot swap fetches the upper option copy in place of the primary.
// [RULE5] Threshold-select rewrite allowed only after chip erase, not block erase.
// [RULE6] Programmer writes zeros to bits 7..1 of the threshold option byte.
// [RULE7] Programmer writes zero to both reserved bytes and their swap copies.
// [RULE8] Debug field: 00 off, 01 prohibited, 10 on, 11 on with erase on failure.
// [RULE9] Without debug support the programmer writes zero to both debug bytes.
// [RULE10] With debug the programmer writes 2 or 3 to both debug bytes alike.
// [RULE11] Decoded settings latched once after reset and held until next reset.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module boot_option_byte_decoder
  import option_byte_pkg::*;
#(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Boot swap strap
  input wire logic boot_swap_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Flash read port used by the boot fetch
  output logic flash_rd_req_o,
  output logic [ADDR_W-1:0] flash_rd_addr_o,
  input wire logic flash_rd_ack_i,
  input wire logic [7:0] flash_rd_data_i,
  // External programmer requests
  input wire logic prog_wr_i,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic chip_erase_i,
  input wire logic block_erase_i,
  // Flash write port
  output flash_wr_t flash_wr_o,
  output logic wr_refused_o,
  // Decoded configuration
  output opt_cfg_t cfg_o,
  output logic cfg_valid_o,
  output logic clear_threshold_select_o,
  output logic debug_ctrl_bit_high_o,
  output logic debug_ctrl_bit_low_o
);

  // Elaboration check: the option copies live up to the swap area
  if (ADDR_W != FLASH_ADDR_W) begin : g_bad_width
    $error("boot_option_byte_decoder: ADDR_W must equal the flash option address width");
  end

  // All state of the top in one record
  typedef struct packed {
    opt_cfg_t cfg;
    logic cfg_valid;
    logic [OPT_BYTES-1:0][7:0] raw;
    logic unlock_pri;
    logic unlock_alt;
    logic refused;
    logic refused_pulse;
    logic self_pend;
    logic [12:0] self_addr;
    logic [7:0] self_data;
    flash_wr_t wr;
    logic [31:0] rdata;
    logic rerr;
  } top_t;

  top_t cur_r, cur_nxt;

  logic [OPT_BYTES-1:0][7:0] fetch_bytes;
  logic fetch_swapped;
  logic fetch_done;
  opt_cfg_t dec_cfg;

  // Boot fetch of the option bytes
  option_fetch u_fetch (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .boot_swap_i(boot_swap_i),
    .rd_req_o(flash_rd_req_o),
    .rd_addr_o(flash_rd_addr_o),
    .rd_ack_i(flash_rd_ack_i),
    .rd_data_i(flash_rd_data_i),
    .bytes_o(fetch_bytes),
    .swapped_o(fetch_swapped),
    .done_o(fetch_done)
  );

  // Field decode of the fetched bytes
  option_decode u_decode (
    .bytes_i(fetch_bytes),
    .swapped_i(fetch_swapped),
    .cfg_o(dec_cfg)
  );

  // Map an APB byte address to a register index; low two bits must be zero
  function automatic logic [9:0] reg_index(input logic [APB_ADDR_W-1:0] a);
    reg_index = a[APB_ADDR_W-1:2];
  endfunction

  // True when a flash address is the threshold option byte, either copy
  function automatic logic is_poc_loc(input logic [12:0] a);
    is_poc_loc = (a == OPT_POC_ADDR) || (a == (OPT_POC_ADDR + OPT_SWAP_OFS));
  endfunction

  logic apb_setup;
  logic apb_wr;
  logic [9:0] rd_idx;
  logic [9:0] wr_idx;
  logic prog_poc;
  logic prog_ok;
  logic self_poc;
  logic self_go;
  logic prog_alt;

  assign apb_setup = psel_i && !penable_i;
  // A misaligned write is answered with an error and must not reach any register
  assign apb_wr = psel_i && penable_i && pwrite_i && (paddr_i[1:0] == 2'h0);
  assign rd_idx = reg_index(paddr_i);
  assign wr_idx = reg_index(paddr_i);
  assign prog_alt = prog_addr_i[12];

  // Threshold byte from the programmer needs the matching unlock from a chip erase
  assign prog_poc = prog_wr_i && is_poc_loc(prog_addr_i);
  assign prog_ok = prog_wr_i && (!prog_poc || (prog_alt ? cur_r.unlock_alt : cur_r.unlock_pri)); // [RULE5]

  // Self-programming waits while the programmer owns the write port
  assign self_poc = is_poc_loc(cur_r.self_addr);
  assign self_go = cur_r.self_pend && !prog_wr_i;

  // Next-state logic for latch, write gate and register file
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.wr.en = 1'b0;
    cur_nxt.refused_pulse = 1'b0;

    // One-time capture when the fetch finishes; never reloaded
    if (fetch_done && !cur_r.cfg_valid) begin
      cur_nxt.cfg = dec_cfg; // [RULE11]
      cur_nxt.raw = fetch_bytes;
      cur_nxt.cfg_valid = 1'b1;
    end

    // Programmer writes: threshold byte only after chip erase
    if (prog_ok) begin
      cur_nxt.wr.en = 1'b1;
      cur_nxt.wr.addr = prog_addr_i;
      cur_nxt.wr.data = prog_data_i;
    end else if (prog_wr_i) begin
      cur_nxt.refused_pulse = 1'b1; // [RULE5]
    end else if (self_go) begin
      cur_nxt.self_pend = 1'b0;
      if (self_poc) begin
        cur_nxt.refused_pulse = 1'b1; // [RULE3]
      end else begin
        cur_nxt.wr.en = 1'b1;
        cur_nxt.wr.addr = cur_r.self_addr;
        cur_nxt.wr.data = cur_r.self_data;
      end
    end

    // An accepted threshold write consumes the unlock of that copy
    if (prog_ok && prog_poc) begin
      if (prog_alt) begin
        cur_nxt.unlock_alt = 1'b0;
      end else begin
        cur_nxt.unlock_pri = 1'b0;
      end
    end
    // Chip erase unlocks both copies and wins over a same-cycle consume; block erase does not
    if (chip_erase_i) begin
      cur_nxt.unlock_pri = 1'b1; // [RULE5]
      cur_nxt.unlock_alt = 1'b1;
    end

    // APB writes to the block's own registers
    if (apb_wr) begin
      if (wr_idx == IDX_SELF_WR && !cur_r.self_pend) begin
        cur_nxt.self_pend = 1'b1;
        cur_nxt.self_data = pwdata_i[SELF_DATA_LSB +: 8];
        cur_nxt.self_addr = pwdata_i[SELF_ADDR_LSB +: 13];
      end
      if (wr_idx == IDX_WR_STAT && pwdata_i[WST_REFUSED]) begin
        cur_nxt.refused = 1'b0;
      end
    end
    // Sticky refusal; a new refusal wins over the clear
    if (cur_nxt.refused_pulse) begin
      cur_nxt.refused = 1'b1;
    end

    // Read data registered in the setup phase, valid in the access phase
    if (apb_setup) begin
      cur_nxt.rdata = 32'h0000_0000;
      cur_nxt.rerr = 1'b0;
      if (paddr_i[1:0] != 2'h0) begin
        cur_nxt.rerr = 1'b1;
      end else begin
        case (rd_idx)
          IDX_POC_OPT: cur_nxt.rdata[7:0] = cur_r.raw[0];
          IDX_RSVA_OPT: cur_nxt.rdata[7:0] = cur_r.raw[1];
          IDX_RSVB_OPT: cur_nxt.rdata[7:0] = cur_r.raw[2];
          IDX_DBG_OPT: cur_nxt.rdata[7:0] = cur_r.raw[3];
          IDX_CFG_STAT: cur_nxt.rdata[9:0] = {cur_r.cfg_valid, cur_r.cfg};
          IDX_SELF_WR: cur_nxt.rdata[20:0] = {cur_r.self_addr, cur_r.self_data};
          IDX_WR_STAT: begin
            cur_nxt.rdata[WST_UNLOCK_PRI] = cur_r.unlock_pri;
            cur_nxt.rdata[WST_UNLOCK_ALT] = cur_r.unlock_alt;
            cur_nxt.rdata[WST_REFUSED] = cur_r.refused;
            cur_nxt.rdata[WST_PENDING] = cur_r.self_pend;
          end
          default: cur_nxt.rerr = 1'b1;
        endcase
      end
    end
  end

  // State register; reset clears both unlocks, so the threshold stays locked until the next chip erase
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // APB answers in the first access cycle, so no wait states
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && cur_r.rerr;
  assign prdata_o = cur_r.rdata;

  // Flash write strobe and refusal pulse
  assign flash_wr_o = cur_r.wr;
  assign wr_refused_o = cur_r.refused_pulse;

  // Latched configuration; stays at reset value until the fetch completes
  assign cfg_o = cur_r.cfg;
  assign cfg_valid_o = cur_r.cfg_valid;
  assign clear_threshold_select_o = cur_r.cfg.poc_dual; // [RULE1] [RULE2]
  assign debug_ctrl_bit_high_o = cur_r.cfg.dbg_field[1];
  assign debug_ctrl_bit_low_o = cur_r.cfg.dbg_field[0];

  // Block erase only reaches the flash; it is deliberately ignored here
  logic unused_block_erase;
  assign unused_block_erase = block_erase_i;

endmodule
`default_nettype wire

// File: core/option_byte_pkg.sv
// Constants, types and carriers shared by the option-byte decoder files
package option_byte_pkg;

  // Flash address width and option locations (primary and boot-swap copies)
  localparam int FLASH_ADDR_W = 13;
  localparam logic [12:0] OPT_POC_ADDR = 13'h0081;
  localparam logic [12:0] OPT_RSVA_ADDR = 13'h0082;
  localparam logic [12:0] OPT_RSVB_ADDR = 13'h0083;
  localparam logic [12:0] OPT_DBG_ADDR = 13'h0084;
  localparam logic [12:0] OPT_SWAP_OFS = 13'h1000;
  localparam int OPT_BYTES = 4;

  // Field positions inside the option bytes
  localparam int POC_SEL_BIT = 0;
  localparam int DBG_LOW_BIT = 0;
  localparam int DBG_HIGH_BIT = 1;

  // Debug control field encodings
  localparam logic [1:0] DBG_OFF = 2'h0;
  localparam logic [1:0] DBG_BAD = 2'h1;
  localparam logic [1:0] DBG_KEEP = 2'h2;
  localparam logic [1:0] DBG_ERASE = 2'h3;

  // Register indices (printed offsets); byte address is four times the index
  localparam logic [9:0] IDX_POC_OPT = 10'h081;
  localparam logic [9:0] IDX_RSVA_OPT = 10'h082;
  localparam logic [9:0] IDX_RSVB_OPT = 10'h083;
  localparam logic [9:0] IDX_DBG_OPT = 10'h084;
  localparam logic [9:0] IDX_CFG_STAT = 10'h000;
  localparam logic [9:0] IDX_SELF_WR = 10'h001;
  localparam logic [9:0] IDX_WR_STAT = 10'h002;
  localparam int APB_ADDR_W = 12;

  // Field positions of the block's own registers
  localparam int SELF_DATA_LSB = 0;
  localparam int SELF_ADDR_LSB = 8;
  localparam int WST_UNLOCK_PRI = 0;
  localparam int WST_UNLOCK_ALT = 1;
  localparam int WST_REFUSED = 2;
  localparam int WST_PENDING = 3;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Decoded configuration carried to the rest of the chip
  typedef struct packed {
    logic poc_dual;
    logic [1:0] dbg_field;
    logic dbg_en;
    logic dbg_erase_on_fail;
    logic dbg_prohibited;
    logic poc_upper_nonzero;
    logic rsv_nonzero;
    logic swapped;
  } opt_cfg_t;

  // One byte write toward the flash array
  typedef struct packed {
    logic en;
    logic [12:0] addr;
    logic [7:0] data;
  } flash_wr_t;

  // Source of a write request
  typedef enum logic {SRC_PROGRAMMER, SRC_SELF} wr_src_t;

endpackage

// File: core/option_decode.sv
// Pure decode of fetched option bytes into the configuration carrier
`timescale 1ns/1ps
`default_nettype none
module option_decode
  import option_byte_pkg::*;
(
  // Raw bytes
  input wire logic [OPT_BYTES-1:0][7:0] bytes_i,
  input wire logic swapped_i,
  // Decoded view
  output opt_cfg_t cfg_o
);

  logic [7:0] poc_b;
  logic [7:0] dbg_b;

  assign poc_b = bytes_i[0];
  assign dbg_b = bytes_i[3];

  // Field decode; a prohibited debug code is reported and leaves debug off
  always_comb begin
    cfg_o = '0;
    cfg_o.poc_dual = poc_b[POC_SEL_BIT]; // [RULE1] [RULE2]
    cfg_o.dbg_field = {dbg_b[DBG_HIGH_BIT], dbg_b[DBG_LOW_BIT]};
    case (cfg_o.dbg_field) // [RULE8]
      DBG_OFF: cfg_o.dbg_en = 1'b0;
      DBG_BAD: cfg_o.dbg_prohibited = 1'b1;
      DBG_KEEP: cfg_o.dbg_en = 1'b1;
      DBG_ERASE: begin
        cfg_o.dbg_en = 1'b1;
        cfg_o.dbg_erase_on_fail = 1'b1;
      end
      default: cfg_o.dbg_en = 1'b0;
    endcase
    cfg_o.poc_upper_nonzero = |poc_b[7:1];
    cfg_o.rsv_nonzero = |{bytes_i[1], bytes_i[2], dbg_b[7:2]};
    cfg_o.swapped = swapped_i;
  end

endmodule
`default_nettype wire

// File: core/option_fetch.sv
// Reads the four option bytes from flash once after reset
`timescale 1ns/1ps
`default_nettype none
module option_fetch
  import option_byte_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Boot swap strap
  input wire logic boot_swap_i,
  // Flash read port
  output logic rd_req_o,
  output logic [FLASH_ADDR_W-1:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [7:0] rd_data_i,
  // Fetched bytes
  output logic [OPT_BYTES-1:0][7:0] bytes_o,
  output logic swapped_o,
  output logic done_o
);

  typedef enum logic [1:0] {F_START, F_READ, F_DONE} fetch_state_t;

  typedef struct packed {
    fetch_state_t st;
    logic swap;
    logic [1:0] idx;
    logic [12:0] addr;
    logic [OPT_BYTES-1:0][7:0] bytes;
  } fetch_t;

  fetch_t cur_r, cur_nxt;

  // Sequencer: strap caught at the first edge after release, then four reads
  always_comb begin
    cur_nxt = cur_r;
    case (cur_r.st)
      F_START: begin
        cur_nxt.swap = boot_swap_i;
        cur_nxt.idx = 2'h0;
        cur_nxt.addr = boot_swap_i ? (OPT_POC_ADDR + OPT_SWAP_OFS) : OPT_POC_ADDR; // [RULE4]
        cur_nxt.st = F_READ;
      end
      F_READ: begin
        if (rd_ack_i) begin
          cur_nxt.bytes[cur_r.idx] = rd_data_i;
          cur_nxt.addr = cur_r.addr + 13'h0001;
          cur_nxt.idx = cur_r.idx + 2'h1;
          if (cur_r.idx == 2'(OPT_BYTES - 1)) begin
            cur_nxt.st = F_DONE;
          end
        end
      end
      F_DONE: cur_nxt.st = F_DONE; // Held until the next reset [RULE11]
      default: cur_nxt.st = F_START;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Request is a level held through all four reads until the flash acknowledges the last byte
  assign rd_req_o = (cur_r.st == F_READ);
  assign rd_addr_o = cur_r.addr;
  assign bytes_o = cur_r.bytes;
  assign swapped_o = cur_r.swap;
  assign done_o = (cur_r.st == F_DONE);

endmodule
`default_nettype wire

// File: dv/flash_model.sv
// Behavioural flash array answering the boot fetch and keeping written bytes
`timescale 1ns/1ps
`default_nettype none
module flash_model
  import option_byte_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Read port, write port and pacing
  input wire logic rd_req_i,
  input wire logic [12:0] rd_addr_i,
  input wire flash_wr_t wr_i,
  input wire logic slow_i,
  output logic rd_ack_o,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:8191];
  logic [1:0] cnt = 2'h0;

  // Data outside an ack cycle toggles so a stale byte is never mistaken for valid
  initial rd_data_o = 8'h5a;
  always @(posedge ref_clk_i) begin
    rd_ack_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (wr_i.en)
      mem[wr_i.addr] <= wr_i.data;
    if (sys_rst_i) begin
      cnt <= 2'h0;
    end else if (rd_req_i && !rd_ack_o) begin
      if (cnt == 2'h0) begin
        rd_ack_o <= 1'b1;
        rd_data_o <= mem[rd_addr_i];
        cnt <= slow_i ? 2'h3 : 2'h0;
      end else begin
        cnt <= cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/option_byte_sva.sv
// Assertion checker for the option byte decoder ports
`timescale 1ns/1ps
`default_nettype none
module option_byte_sva
  import option_byte_pkg::*;
#(
  parameter int ADDR_W = FLASH_ADDR_W
) (
  // Clock, reset and strap
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic boot_swap_i,
  // Flash traffic
  input wire logic flash_rd_req_o,
  input wire logic [ADDR_W-1:0] flash_rd_addr_o,
  input wire logic flash_rd_ack_i,
  input wire logic [7:0] flash_rd_data_i,
  input wire logic prog_wr_i,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  input wire logic chip_erase_i,
  input wire flash_wr_t flash_wr_o,
  input wire logic wr_refused_o,
  // Decoded settings
  input wire opt_cfg_t cfg_o,
  input wire logic cfg_valid_o,
  input wire logic clear_threshold_select_o
);
  logic poc_b;
  logic unl_r;
  logic [1:0] dbg_b;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Mirror of the fetched threshold bit and debug field and of the primary unlock; only acks under a request count
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      poc_b <= 1'b0;
      dbg_b <= 2'h0;
      unl_r <= 1'b0;
    end else begin
      if (flash_rd_req_o && flash_rd_ack_i && flash_rd_addr_o[7:0] == 8'h81)
        poc_b <= flash_rd_data_i[0];
      if (flash_rd_req_o && flash_rd_ack_i && flash_rd_addr_o[7:0] == 8'h84)
        dbg_b <= flash_rd_data_i[1:0];
      // Consumed at the edge that takes the write; a same-cycle chip erase keeps it open
      if (chip_erase_i)
        unl_r <= 1'b1;
      else if (prog_wr_i && prog_addr_i == OPT_POC_ADDR)
        unl_r <= 1'b0;
    end
  end

  a_poc_single: assert property (cfg_valid_o && !poc_b
    |-> !cfg_o.poc_dual && !clear_threshold_select_o) else $error("single threshold mode wrong");
  a_poc_dual: assert property (cfg_valid_o && poc_b
    |-> cfg_o.poc_dual && clear_threshold_select_o) else $error("dual threshold mode wrong");
  a_prog_only: assert property (flash_wr_o.en && flash_wr_o.addr[11:0] == 12'h081
    |-> $past(prog_wr_i) && $past(prog_addr_i) == flash_wr_o.addr) else $error("threshold byte written by self");
  a_swap_copy: assert property (flash_rd_req_o
    |-> flash_rd_addr_o[12] == boot_swap_i && flash_rd_addr_o[11:0] inside {[12'h081:12'h084]})
    else $error("fetch from wrong copy");
  a_relock_hold: assert property (prog_wr_i && prog_addr_i == OPT_POC_ADDR && !unl_r && !chip_erase_i
    |=> wr_refused_o && !flash_wr_o.en) else $error("locked threshold byte written");
  a_dbg_decode: assert property (cfg_valid_o
    |-> cfg_o.dbg_field == dbg_b && cfg_o.dbg_en == dbg_b[1] && cfg_o.dbg_erase_on_fail == &dbg_b
    && cfg_o.dbg_prohibited == (dbg_b == 2'h1)) else $error("debug field decode wrong");
  a_cfg_hold: assert property (cfg_valid_o |=> cfg_valid_o && $stable(cfg_o))
    else $error("settings changed before reset");
endmodule

bind boot_option_byte_decoder option_byte_sva #(.ADDR_W(ADDR_W)) u_sva (
  .ref_clk_i, .sys_rst_i, .boot_swap_i, .flash_rd_req_o, .flash_rd_addr_o, .flash_rd_ack_i,
  .flash_rd_data_i, .prog_wr_i, .prog_addr_i, .chip_erase_i, .flash_wr_o, .wr_refused_o,
  .cfg_o, .cfg_valid_o, .clear_threshold_select_o
);
`default_nettype wire

// File: dv/test_boot_option_byte_decoder.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module test_boot_option_byte_decoder
  import option_byte_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i, boot_swap_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, slow;
  logic flash_rd_req_o, flash_rd_ack_i, prog_wr_i, chip_erase_i, block_erase_i, wr_refused_o;
  logic cfg_valid_o, clear_threshold_select_o, debug_ctrl_bit_high_o, debug_ctrl_bit_low_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [12:0] flash_rd_addr_o, prog_addr_i;
  logic [7:0] flash_rd_data_i, prog_data_i;
  flash_wr_t flash_wr_o;
  opt_cfg_t cfg_o;
  int fail_count, n_checks, cyc;

  always #2.5 ref_clk_i = ~ref_clk_i;

  boot_option_byte_decoder dut (
    .ref_clk_i, .sys_rst_i, .boot_swap_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .flash_rd_req_o, .flash_rd_addr_o, .flash_rd_ack_i,
    .flash_rd_data_i, .prog_wr_i, .prog_addr_i, .prog_data_i, .chip_erase_i, .block_erase_i,
    .flash_wr_o, .wr_refused_o, .cfg_o, .cfg_valid_o, .clear_threshold_select_o,
    .debug_ctrl_bit_high_o, .debug_ctrl_bit_low_o
  );
  flash_model flash (
    .ref_clk_i, .sys_rst_i, .rd_req_i(flash_rd_req_o), .rd_addr_i(flash_rd_addr_o), .wr_i(flash_wr_o),
    .slow_i(slow), .rd_ack_o(flash_rd_ack_i), .rd_data_o(flash_rd_data_i)
  );

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: a full run needs a few hundred cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // APB master: request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // No local limit: only the bench timeout may end this wait
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Waits for the outcome of one write and judges it
  task res(input logic [12:0] a, input logic [7:0] d, input logic ok);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (flash_wr_o.en !== 1'b1 && wr_refused_o !== 1'b1 && n < 8);
    chk({31'h0, flash_wr_o.en}, {31'h0, ok});
    chk({31'h0, wr_refused_o}, {31'h0, ~ok});
    if (ok)
      chk({19'h0, flash_wr_o.addr, flash_wr_o.data}, {19'h0, a, d});
  endtask

  task pw(input logic [12:0] a, input logic [7:0] d, input logic ok);
    @(posedge ref_clk_i);
    prog_wr_i <= 1'b1;
    prog_addr_i <= a;
    prog_data_i <= d;
    @(posedge ref_clk_i);
    prog_wr_i <= 1'b0;
    res(a, d, ok);
  endtask

  task ers(input logic c);
    @(posedge ref_clk_i);
    chip_erase_i <= c;
    block_erase_i <= ~c;
    @(posedge ref_clk_i);
    chip_erase_i <= 1'b0;
    block_erase_i <= 1'b0;
  endtask

  // Boot with threshold copies that differ, so the decoded value shows which copy was used
  task boot(input logic s, input logic [1:0] k);
    logic p;
    logic [1:0] d;
    opt_cfg_t e;
    int n;
    p = k[0] ^ s;
    d = k;
    flash.mem[13'h0081] = {7'h00, k[0]};
    flash.mem[13'h1081] = {7'h00, ~k[0]};
    for (n = 2; n < 4; n++) begin
      flash.mem[13'h0080 + n] = 8'h00;
      flash.mem[13'h1080 + n] = 8'h00;
    end
    flash.mem[13'h0084] = {6'h00, k};
    flash.mem[13'h1084] = {6'h00, k};
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    boot_swap_i <= s;
    slow <= k[1];
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    n = 0;
    while (cfg_valid_o !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    e = '0;
    e.poc_dual = p;
    e.dbg_field = d;
    e.dbg_en = d[1];
    e.dbg_erase_on_fail = &d;
    e.dbg_prohibited = (d == 2'h1);
    e.swapped = s;
    chk({23'h0, cfg_o}, {23'h0, e});
    chk({30'h0, debug_ctrl_bit_high_o, debug_ctrl_bit_low_o}, {30'h0, d});
    chk({31'h0, clear_threshold_select_o}, {31'h0, p});
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, {22'h0, 1'b1, e});
    apb(1'b0, 12'h204, 32'h0, rd, er);
    chk(rd, {31'h0, p});
    apb(1'b0, 12'h210, 32'h0, rd, er);
    chk(rd, {30'h0, d});
  endtask

  // Programmer and self writes against the threshold lock, then bus errors
  task wr_seq;
    pw(13'h0081, 8'h01, 1'b0);
    ers(1'b0);
    pw(13'h0081, 8'h01, 1'b0);
    ers(1'b1);
    pw(13'h0081, 8'h01, 1'b1);
    pw(13'h0081, 8'h00, 1'b0);
    pw(13'h1084, 8'h03, 1'b1);
    ers(1'b1);
    apb(1'b1, 12'h004, {11'h0, 13'h0081, 8'h01}, rd, er);
    res(13'h0081, 8'h01, 1'b0);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk(rd & 32'h4, 32'h4);
    pw(13'h0081, 8'h01, 1'b1);
    apb(1'b1, 12'h004, {11'h0, 13'h0082, 8'h00}, rd, er);
    res(13'h0082, 8'h00, 1'b1);
    apb(1'b0, 12'h400, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h204, 32'hff, rd, er);
    apb(1'b0, 12'h204, 32'h0, rd, er);
    chk(rd, 32'h0);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    boot_swap_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    prog_wr_i = 1'b0;
    prog_addr_i = 13'h0000;
    prog_data_i = 8'h00;
    chip_erase_i = 1'b0;
    block_erase_i = 1'b0;
    slow = 1'b0;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    for (int i = 0; i < 8; i++) begin
      boot(i[2], i[1:0]);
    end
    wr_seq();
    end_sim();
  end
endmodule
`default_nettype wire
